// *** verilog/serial_shift_pkg.sv ***
package serial_shift_pkg;

  localparam int DATA_W = 8;
  localparam int CNT_W  = 4;

  localparam logic [7:0] ADDR_STATUS  = 8'h2B;
  localparam logic [7:0] ADDR_CONTROL = 8'h2D;
  localparam logic [7:0] ADDR_DATA    = 8'h2F;
  localparam logic [7:0] ADDR_BUFFER  = 8'h30;
  localparam logic [7:0] ADDR_PORT    = 8'h31;

  localparam int ST_START = 7;
  localparam int ST_OVF   = 6;
  localparam int ST_STOP  = 5;
  localparam int ST_COLL  = 4;
  localparam int ST_CNT   = 0;

  localparam int CR_SIE = 7;
  localparam int CR_OIE = 6;
  localparam int CR_WM  = 4;
  localparam int CR_CS  = 2;
  localparam int CR_CLK = 1;
  localparam int CR_TC  = 0;

  localparam int PT_CLK_VAL = 0;
  localparam int PT_CLK_DIR = 1;
  localparam int PT_DO_VAL  = 2;
  localparam int PT_DO_DIR  = 3;
  localparam int PT_SDA_VAL = 4;
  localparam int PT_SDA_DIR = 5;

  localparam logic [7:0]       STATUS_RST  = 8'h00;
  localparam logic [7:0]       CONTROL_RST = 8'h00;
  localparam logic [7:0]       DATA_RST    = 8'h00;
  localparam logic [7:0]       BUFFER_RST  = 8'h00;
  localparam logic [5:0]       PORT_RST    = 6'h00;
  localparam logic [CNT_W-1:0] CNT_LAST    = 4'hF;

  typedef enum logic [1:0] {
    CS_SOFT    = 2'b00,
    CS_TIMER   = 2'b01,
    CS_EXT_POS = 2'b10,
    CS_EXT_NEG = 2'b11
  } clk_src_t;

  typedef enum logic [1:0] {
    WM_OFF      = 2'b00,
    WM_THREE    = 2'b01,
    WM_TWO      = 2'b10,
    WM_TWO_HOLD = 2'b11
  } wire_mode_t;

  typedef struct packed {
    logic       start_ie;
    logic       overflow_ie;
    wire_mode_t wire_mode;
    clk_src_t   clock_source_select;
    logic       clock_strobe;
  } ctrl_t;

  typedef struct packed {
    logic sda_dir;
    logic sda_val;
    logic do_dir;
    logic do_val;
    logic clk_dir;
    logic clk_val;
  } port_t;

  typedef struct packed {
    ctrl_t             ctrl;
    port_t             port;
    logic [DATA_W-1:0] shift_data;
    logic [DATA_W-1:0] rx_buffer;
    logic [CNT_W-1:0]  transfer_counter;
    logic              start_flag;
    logic              overflow_flag;
    logic              stop_flag;
    logic              din_prev;
    logic              out_latch;
    logic              clk_pin_o;
    logic              clk_pin_oe;
    logic              dout;
    logic              dout_oe;
    logic              sda_out;
    logic              sda_oe;
    logic              start_irq;
    logic              overflow_irq;
    logic              wake_any;
    logic              wake_idle;
    logic [7:0]        rd_data;
  } unit_state_t;

endpackage : serial_shift_pkg

// *** verilog/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH  = 2,
  parameter int STAGES = 2
) (
  input  wire logic             clk_sys_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage_r [STAGES];

  if (STAGES < 2) begin : g_bad_stages
    $error("pin_sync needs at least two stages");
  end

  // Each bit passes the full chain before any logic sees it.
  // Stages reset high, the idle level of the serial lines, so that no
  // false edge reaches the edge detector after reset.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_r[i] <= '1;
      end
    end else begin
      stage_r[0] <= async_i;
      for (int i = 1; i < STAGES; i++) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  assign sync_o = stage_r[STAGES-1];

endmodule : pin_sync

// *** verilog/line_event_detect.sv ***
`timescale 1ns/1ps
module line_event_detect (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_rise_o,
  output logic      scl_fall_o,
  output logic      start_o,
  output logic      stop_o
);

  logic scl_prev_r;
  logic sda_prev_r;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_prev_r <= scl_i;
      sda_prev_r <= sda_i;
    end
  end

  // Edges of the serial clock and bus conditions while the clock is high.
  assign scl_rise_o = scl_i & ~scl_prev_r;
  assign scl_fall_o = ~scl_i & scl_prev_r;
  assign start_o    = scl_i & scl_prev_r & sda_prev_r & ~sda_i;
  assign stop_o     = scl_i & scl_prev_r & ~sda_prev_r & sda_i;

endmodule : line_event_detect

// *** verilog/universal_serial_shift_unit.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Source zero: shift and count only on strobe
// - Source 01: timer match clocks shift and counter
// - External: chosen edge shifts, both edges count
// - External with strobe set: toggle writes count
// - Output latch always open on sources 00 and 01, first half only on external
// - Strobe: output now, input from previous cycle
// - Strobe and toggle bits act on one, read zero
// - Toggle inverts clock port value, direction gates pin
// - Start flag: bus start, or any clock edge
// - Start flag cleared by one, releases hold
// - Start wakes all sleeps, overflow only idle
// - Overflow on 15 to 0 wrap, one clears
// - Stop flag in two-wire mode, no interrupt
// - Collision reads data bit seven versus pin
// - Counter readable and writable in status low bits
// - Wire mode off still clocks counter and data
// - Shift left; a write beats a shift
// - Data pin follows bit seven through latch in mode 01 only; two-wire modes drive SDA from the latch
// - Completed transfer copies data into buffer
// - Two-wire start holds clock low until cleared
// - Mode 11 overflow holds clock low until cleared
module universal_serial_shift_unit (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       timer_match_i,
  input  wire logic       clk_pin_i,
  output logic            clk_pin_o,
  output logic            clk_pin_oe_o,
  input  wire logic       din_pin_i,
  output logic            dout_pin_o,
  output logic            dout_pin_oe_o,
  output logic            sda_pin_o,
  output logic            sda_pin_oe_o,
  output logic            start_irq_o,
  output logic            overflow_irq_o,
  output logic            wake_any_sleep_o,
  output logic            wake_idle_o
);

  serial_shift_pkg::unit_state_t s_r;
  serial_shift_pkg::unit_state_t s_nxt;
  serial_shift_pkg::ctrl_t       ctrl_eff;

  logic [1:0] pins_sync;
  logic       scl_s;
  logic       din_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;

  logic       wr_status;
  logic       wr_ctrl;
  logic       wr_data;
  logic       wr_port;
  logic       sw_strobe;
  logic       toggle;
  logic       shift_ev;
  logic       count_ev;
  logic       wrap;
  logic       two_wire;
  logic       transparent;
  logic       scl_hold;
  logic [7:0] status_view;

  pin_sync #(
    .WIDTH  (2),
    .STAGES (2)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .async_i   ({clk_pin_i, din_pin_i}),
    .sync_o    (pins_sync)
  );

  assign scl_s = pins_sync[1];
  assign din_s = pins_sync[0];

  line_event_detect u_events (
    .clk_sys_i  (clk_sys_i),
    .nrst_i     (nrst_i),
    .scl_i      (scl_s),
    .sda_i      (din_s),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .start_o    (bus_start),
    .stop_o     (bus_stop)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  always_comb begin
    s_nxt     = s_r;
    wr_status = wr_i && hit(addr_i, serial_shift_pkg::ADDR_STATUS);
    wr_ctrl   = wr_i && hit(addr_i, serial_shift_pkg::ADDR_CONTROL);
    wr_data   = wr_i && hit(addr_i, serial_shift_pkg::ADDR_DATA);
    wr_port   = wr_i && hit(addr_i, serial_shift_pkg::ADDR_PORT);

    ctrl_eff = s_r.ctrl;
    if (wr_ctrl) begin
      ctrl_eff.start_ie    = wdata_i[serial_shift_pkg::CR_SIE];
      ctrl_eff.overflow_ie = wdata_i[serial_shift_pkg::CR_OIE];
      ctrl_eff.wire_mode   = serial_shift_pkg::wire_mode_t'(
                               wdata_i[serial_shift_pkg::CR_WM +: 2]);
      ctrl_eff.clock_source_select = serial_shift_pkg::clk_src_t'(
                               wdata_i[serial_shift_pkg::CR_CS +: 2]);
      ctrl_eff.clock_strobe = wdata_i[serial_shift_pkg::CR_CLK];
    end
    s_nxt.ctrl = ctrl_eff;
    two_wire   = ctrl_eff.wire_mode[1];

    sw_strobe = wr_ctrl && wdata_i[serial_shift_pkg::CR_CLK];
    toggle    = wr_ctrl && wdata_i[serial_shift_pkg::CR_TC];

    // Clock source selection ignores wire mode.
    unique case (ctrl_eff.clock_source_select)
      serial_shift_pkg::CS_SOFT: begin
        shift_ev = sw_strobe;
        count_ev = sw_strobe;
      end
      serial_shift_pkg::CS_TIMER: begin
        shift_ev = timer_match_i;
        count_ev = timer_match_i;
      end
      serial_shift_pkg::CS_EXT_POS: begin
        shift_ev = scl_rise;
        count_ev = ctrl_eff.clock_strobe ? toggle : (scl_rise | scl_fall);
      end
      serial_shift_pkg::CS_EXT_NEG: begin
        shift_ev = scl_fall;
        count_ev = ctrl_eff.clock_strobe ? toggle : (scl_rise | scl_fall);
      end
    endcase

    if (wr_data) begin
      s_nxt.shift_data = wdata_i;
    end else if (shift_ev) begin
      s_nxt.shift_data = {s_r.shift_data[6:0], s_r.din_prev};
    end
    s_nxt.din_prev = din_s;

    wrap = 1'b0;
    if (wr_status) begin
      s_nxt.transfer_counter = wdata_i[serial_shift_pkg::ST_CNT +: 4];
    end else if (count_ev) begin
      s_nxt.transfer_counter = s_r.transfer_counter + 4'h1;
      wrap = (s_r.transfer_counter == serial_shift_pkg::CNT_LAST);
    end

    if (wrap) begin
      s_nxt.rx_buffer = s_nxt.shift_data;
    end

    if (wr_status && wdata_i[serial_shift_pkg::ST_START]) begin
      s_nxt.start_flag = 1'b0;
    end
    if (two_wire ? bus_start : (scl_rise | scl_fall)) begin
      s_nxt.start_flag = 1'b1;
    end

    if (wr_status && wdata_i[serial_shift_pkg::ST_OVF]) begin
      s_nxt.overflow_flag = 1'b0;
    end
    if (wrap) begin
      s_nxt.overflow_flag = 1'b1;
    end

    if (wr_status && wdata_i[serial_shift_pkg::ST_STOP]) begin
      s_nxt.stop_flag = 1'b0;
    end
    if (two_wire && bus_stop) begin
      s_nxt.stop_flag = 1'b1;
    end

    if (wr_port) begin
      s_nxt.port = serial_shift_pkg::port_t'(wdata_i[5:0]);
    end
    if (toggle) begin
      s_nxt.port.clk_val = ~s_nxt.port.clk_val;
    end

    // Latch always open on sources 00 and 01, first half only on external.
    if (!ctrl_eff.clock_source_select[1]) begin
      transparent = 1'b1;
    end else if (ctrl_eff.clock_source_select == serial_shift_pkg::CS_EXT_POS)
    begin
      transparent = ~scl_s;
    end else begin
      transparent = scl_s;
    end
    if (transparent) begin
      s_nxt.out_latch = s_nxt.shift_data[7];
    end

    scl_hold = (two_wire && s_nxt.start_flag) ||
               (ctrl_eff.wire_mode == serial_shift_pkg::WM_TWO_HOLD &&
                s_nxt.overflow_flag);

    unique case (ctrl_eff.wire_mode)
      serial_shift_pkg::WM_OFF: begin
        s_nxt.clk_pin_o  = s_nxt.port.clk_val;
        s_nxt.clk_pin_oe = s_nxt.port.clk_dir;
        s_nxt.dout       = s_nxt.port.do_val;
        s_nxt.dout_oe    = s_nxt.port.do_dir;
        s_nxt.sda_out    = s_nxt.port.sda_val;
        s_nxt.sda_oe     = s_nxt.port.sda_dir;
      end
      serial_shift_pkg::WM_THREE: begin
        s_nxt.clk_pin_o  = s_nxt.port.clk_val;
        s_nxt.clk_pin_oe = s_nxt.port.clk_dir;
        s_nxt.dout       = s_nxt.out_latch;
        s_nxt.dout_oe    = s_nxt.port.do_dir;
        s_nxt.sda_out    = s_nxt.port.sda_val;
        s_nxt.sda_oe     = s_nxt.port.sda_dir;
      end
      default: begin
        s_nxt.clk_pin_o  = 1'b0;
        s_nxt.clk_pin_oe = s_nxt.port.clk_dir &&
                           (!s_nxt.port.clk_val || scl_hold);
        s_nxt.dout       = s_nxt.port.do_val;
        s_nxt.dout_oe    = s_nxt.port.do_dir;
        s_nxt.sda_out    = 1'b0;
        s_nxt.sda_oe     = s_nxt.port.sda_dir &&
                           (!s_nxt.out_latch || !s_nxt.port.sda_val);
      end
    endcase

    // Start interrupt while flag and enable set.
    s_nxt.start_irq    = s_nxt.start_flag && ctrl_eff.start_ie;
    s_nxt.overflow_irq = s_nxt.overflow_flag && ctrl_eff.overflow_ie;
    s_nxt.wake_any     = s_nxt.start_irq;
    s_nxt.wake_idle    = s_nxt.overflow_irq;

    // Collision compares bit seven with the pin.
    status_view = {s_r.start_flag, s_r.overflow_flag, s_r.stop_flag,
                   s_r.shift_data[7] ^ din_s, s_r.transfer_counter};

    s_nxt.rd_data = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        serial_shift_pkg::ADDR_STATUS:  s_nxt.rd_data = status_view;
        serial_shift_pkg::ADDR_CONTROL: s_nxt.rd_data = {
          s_r.ctrl.start_ie, s_r.ctrl.overflow_ie, s_r.ctrl.wire_mode,
          s_r.ctrl.clock_source_select, 2'b00};
        serial_shift_pkg::ADDR_DATA:    s_nxt.rd_data = s_r.shift_data;
        serial_shift_pkg::ADDR_BUFFER:  s_nxt.rd_data = s_r.rx_buffer;
        serial_shift_pkg::ADDR_PORT:    s_nxt.rd_data = {2'b00, s_r.port};
        default:                        s_nxt.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r                  <= '0;
      s_r.ctrl             <= serial_shift_pkg::ctrl_t'(
                                serial_shift_pkg::CONTROL_RST[7:1]);
      s_r.port             <= serial_shift_pkg::PORT_RST;
      s_r.shift_data       <= serial_shift_pkg::DATA_RST;
      s_r.rx_buffer        <= serial_shift_pkg::BUFFER_RST;
      s_r.transfer_counter <= serial_shift_pkg::STATUS_RST[3:0];
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o          = s_r.rd_data;
  assign clk_pin_o        = s_r.clk_pin_o;
  assign clk_pin_oe_o     = s_r.clk_pin_oe;
  assign dout_pin_o       = s_r.dout;
  assign dout_pin_oe_o    = s_r.dout_oe;
  assign sda_pin_o        = s_r.sda_out;
  assign sda_pin_oe_o     = s_r.sda_oe;
  assign start_irq_o      = s_r.start_irq;
  assign overflow_irq_o   = s_r.overflow_irq;
  assign wake_any_sleep_o = s_r.wake_any;
  assign wake_idle_o      = s_r.wake_idle;

endmodule : universal_serial_shift_unit

// *** sim/universal_serial_shift_unit_checker.sv ***
`timescale 1ns/1ps
module universal_serial_shift_unit_checker (
  input wire logic       clk_sys_i,
  input wire logic       nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       clk_pin_o,
  input wire logic       clk_pin_oe_o,
  input wire logic       dout_pin_oe_o,
  input wire logic       start_irq_o,
  input wire logic       overflow_irq_o,
  input wire logic       wake_any_sleep_o,
  input wire logic       wake_idle_o
);
  localparam logic [7:0] A_CT = serial_shift_pkg::ADDR_CONTROL;
  localparam logic [7:0] A_PT = serial_shift_pkg::ADDR_PORT;
  logic [7:0] ctl_r;
  logic [5:0] prt_r;

  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  // Copies of the control and port registers as software wrote them.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_r <= 8'h00;
      prt_r <= 6'h00;
    end else if (wr_i && addr_i == A_CT) begin
      ctl_r <= wdata_i;
    end else if (wr_i && addr_i == A_PT) begin
      prt_r <= wdata_i[5:0];
    end
  end

  a_strobe_read_zero: assert property (
    rd_i && addr_i == A_CT |=> rdata_o[1:0] == 2'b00)
    else $error("strobe bits read as one");
  a_toggle_inverts: assert property (
    !ctl_r[5] && wr_i && addr_i == A_CT && wdata_i[0] && !wdata_i[5]
    |=> clk_pin_o != $past(clk_pin_o))
    else $error("toggle did not invert the clock pin");
  a_clk_oe_dir: assert property (
    !prt_r[1] && !$past(prt_r[1]) |-> !clk_pin_oe_o)
    else $error("clock pin driven without direction");
  a_dout_oe_dir: assert property (
    !prt_r[3] && !$past(prt_r[3]) |-> !dout_pin_oe_o)
    else $error("data pin driven without direction");
  a_two_wire_clk: assert property (
    ctl_r[5] && $past(ctl_r[5]) |-> !clk_pin_o)
    else $error("clock pin value high in two-wire mode");
  a_start_irq_gate: assert property (
    !ctl_r[7] && !$past(ctl_r[7]) |-> !start_irq_o)
    else $error("start interrupt while disabled");
  a_ovf_irq_gate: assert property (
    !ctl_r[6] && !$past(ctl_r[6]) |-> !overflow_irq_o)
    else $error("overflow interrupt while disabled");
  a_wake_any_start: assert property (
    wake_any_sleep_o == start_irq_o)
    else $error("any-sleep wake differs from start interrupt");
  a_wake_idle_ovf: assert property (
    wake_idle_o == overflow_irq_o)
    else $error("idle wake differs from overflow interrupt");

  c_overflow: cover property ($rose(overflow_irq_o));
  c_start: cover property ($rose(start_irq_o));
  c_hold: cover property ($rose(clk_pin_oe_o));
endmodule : universal_serial_shift_unit_checker

bind universal_serial_shift_unit universal_serial_shift_unit_checker chk_u (
  .clk_sys_i        (clk_sys_i),
  .nrst_i           (nrst_i),
  .addr_i           (addr_i),
  .wdata_i          (wdata_i),
  .wr_i             (wr_i),
  .rd_i             (rd_i),
  .rdata_o          (rdata_o),
  .clk_pin_o        (clk_pin_o),
  .clk_pin_oe_o     (clk_pin_oe_o),
  .dout_pin_oe_o    (dout_pin_oe_o),
  .start_irq_o      (start_irq_o),
  .overflow_irq_o   (overflow_irq_o),
  .wake_any_sleep_o (wake_any_sleep_o),
  .wake_idle_o      (wake_idle_o)
);

// *** sim/serial_link_partner.sv ***
`timescale 1ns/1ps
module serial_link_partner (
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Clock stands high between frames; data changes while it is low.
  task automatic send_byte(input logic [7:0] b);
    #3;
    for (int i = 7; i >= 0; i--) begin
      scl_o = 1'b0;
      sda_o = b[i];
      #80;
      scl_o = 1'b1;
      #80;
    end
    // The released data line shows the inverse of the last bit.
    sda_o = ~b[0];
  endtask : send_byte

  // Data falls while the clock stays high.
  task automatic bus_start();
    #3;
    sda_o = 1'b0;
    #80;
  endtask : bus_start

  // Data rises while the clock stays high.
  task automatic bus_stop();
    #3;
    sda_o = 1'b0;
    #80;
    sda_o = 1'b1;
    #80;
  endtask : bus_stop
endmodule : serial_link_partner

// *** sim/tb_universal_serial_shift_unit.sv ***
`timescale 1ns/1ps
module tb_universal_serial_shift_unit;
  localparam logic [7:0] A_ST = serial_shift_pkg::ADDR_STATUS;
  localparam logic [7:0] A_CT = serial_shift_pkg::ADDR_CONTROL;
  localparam logic [7:0] A_DT = serial_shift_pkg::ADDR_DATA;
  localparam logic [7:0] A_BF = serial_shift_pkg::ADDR_BUFFER;
  localparam logic [7:0] A_PT = serial_shift_pkg::ADDR_PORT;
  localparam logic [7:0] RST_A [5] = '{A_ST, A_CT, A_DT, A_BF, 8'h00};
  localparam logic [7:0] RST_E [5] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
  logic       clk_sys_i;
  logic       nrst_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic       timer_match_i;
  logic [7:0] rdata_o;
  logic       clk_pin_o;
  logic       clk_pin_oe_o;
  logic       dout_pin_o;
  logic       dout_pin_oe_o;
  logic       sda_pin_o;
  logic       sda_pin_oe_o;
  logic       start_irq_o;
  logic       overflow_irq_o;
  logic       wake_any_sleep_o;
  logic       wake_idle_o;
  logic       p_scl;
  logic       p_sda;
  logic       clk_wire;
  logic       din_wire;
  logic [7:0] rv;
  int         error_cnt = 0;
  int         checked = 0;
  int         cyc = 0;

  // A driving design pin wins over the far side.
  assign clk_wire = clk_pin_oe_o ? clk_pin_o : p_scl;
  assign din_wire = sda_pin_oe_o ? sda_pin_o : p_sda;

  universal_serial_shift_unit dut_u (
    .clk_sys_i        (clk_sys_i),
    .nrst_i           (nrst_i),
    .addr_i           (addr_i),
    .wdata_i          (wdata_i),
    .wr_i             (wr_i),
    .rd_i             (rd_i),
    .rdata_o          (rdata_o),
    .timer_match_i    (timer_match_i),
    .clk_pin_i        (clk_wire),
    .clk_pin_o        (clk_pin_o),
    .clk_pin_oe_o     (clk_pin_oe_o),
    .din_pin_i        (din_wire),
    .dout_pin_o       (dout_pin_o),
    .dout_pin_oe_o    (dout_pin_oe_o),
    .sda_pin_o        (sda_pin_o),
    .sda_pin_oe_o     (sda_pin_oe_o),
    .start_irq_o      (start_irq_o),
    .overflow_irq_o   (overflow_irq_o),
    .wake_any_sleep_o (wake_any_sleep_o),
    .wake_idle_o      (wake_idle_o)
  );

  serial_link_partner partner_u (
    .scl_o (p_scl),
    .sda_o (p_sda)
  );

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d,
                        input logic tm = 1'b0);
    @(posedge clk_sys_i);
    addr_i        <= a;
    wdata_i       <= d;
    wr_i          <= 1'b1;
    timer_match_i <= tm;
    @(posedge clk_sys_i);
    wr_i          <= 1'b0;
    timer_match_i <= 1'b0;
  endtask : bus_wr

  task automatic chk_rd(input string nm, input logic [7:0] a,
                        input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    rv = rdata_o;
    cmp(nm, e, rv & m);
  endtask : chk_rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    nrst_i        = 1'b0;
    addr_i        = 8'h00;
    wdata_i       = 8'h00;
    wr_i          = 1'b0;
    rd_i          = 1'b0;
    timer_match_i = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    foreach (RST_A[i]) begin
      chk_rd("reset", RST_A[i], RST_E[i]);
    end
    bus_wr(A_CT, 8'h10);
    bus_wr(A_PT, 8'h08);
    bus_wr(A_DT, 8'h80);
    tick(3);
    cmp("dout", 8'h03, {6'h00, dout_pin_oe_o, dout_pin_o});
    bus_wr(A_CT, 8'h12);
    tick(3);
    cmp("dout", 8'h02, {6'h00, dout_pin_oe_o, dout_pin_o});
    chk_rd("data", A_DT, 8'h01);
    chk_rd("status", A_ST, 8'h11);
    chk_rd("control", A_CT, 8'h10);
    bus_wr(A_ST, 8'h0F);
    bus_wr(A_CT, 8'h52);
    tick(2);
    cmp("wake", 8'h03, {5'h00, wake_any_sleep_o, wake_idle_o,
                        overflow_irq_o});
    chk_rd("status", A_ST, 8'h50);
    chk_rd("buffer", A_BF, 8'h03);
    bus_wr(A_ST, 8'h40);
    tick(2);
    cmp("ovf irq", 8'h00, {7'h00, overflow_irq_o});
    bus_wr(A_CT, 8'h04);
    bus_wr(A_ST, 8'hE0);
    bus_wr(A_DT, 8'h01, 1'b1);
    repeat (3) begin
      @(posedge clk_sys_i);
      timer_match_i <= 1'b1;
      @(posedge clk_sys_i);
      timer_match_i <= 1'b0;
    end
    chk_rd("data", A_DT, 8'h0F);
    chk_rd("status", A_ST, 8'h14);
    bus_wr(A_CT, 8'h08);
    bus_wr(A_ST, 8'hE0);
    partner_u.send_byte(8'hC5);
    tick(10);
    chk_rd("data", A_DT, 8'hC5);
    chk_rd("buffer", A_BF, 8'hC5);
    chk_rd("status", A_ST, 8'hD0);
    bus_wr(A_ST, 8'hE0);
    bus_wr(A_CT, 8'h1E);
    repeat (3) bus_wr(A_CT, 8'h1F);
    tick(2);
    cmp("clk pin", 8'h01, {6'h00, clk_pin_oe_o, clk_pin_o});
    chk_rd("count", A_ST, 8'h03, 8'h0F);
    chk_rd("control", A_CT, 8'h1C);
    partner_u.bus_stop();
    bus_wr(A_CT, 8'hA0);
    bus_wr(A_PT, 8'h03);
    bus_wr(A_ST, 8'hE0);
    partner_u.bus_start();
    tick(6);
    cmp("hold", 8'h07, {5'h00, clk_pin_oe_o, wake_any_sleep_o,
                        start_irq_o});
    chk_rd("flags", A_ST, 8'h80, 8'hE0);
    bus_wr(A_ST, 8'h80);
    tick(3);
    cmp("hold", 8'h00, {6'h00, clk_pin_oe_o, start_irq_o});
    partner_u.bus_stop();
    tick(6);
    chk_rd("flags", A_ST, 8'h20, 8'hE0);
    cmp("irq", 8'h00, {6'h00, start_irq_o, overflow_irq_o});
    bus_wr(A_CT, 8'h30);
    bus_wr(A_ST, 8'hEF);
    bus_wr(A_CT, 8'h32);
    tick(2);
    cmp("ovf hold", 8'h01, {7'h00, clk_pin_oe_o});
    bus_wr(A_ST, 8'h40);
    tick(2);
    cmp("ovf hold", 8'h00, {7'h00, clk_pin_oe_o});
    final_report();
  end
endmodule : tb_universal_serial_shift_unit
